// [hw/wdt_top.sv]
// Function
// - Enabled count decrements every clock
// - Key write restarts count, no timeout
// - Load value is two to select+16
// - New select applies at service, zero or a later enable
// - Count readable as four byte registers
// - All-zero count means timeout
// - Lock freezes enable; only reset clears lock
// - Response 11: interrupt then reset second
// - Response 00: every timeout resets
// - Disabled: count holds except on key write, no events
// - Valid key clears pending interrupt
// - Status bit 7 shows interrupt occurred
// - Status bit 6 low after watchdog reset
// - Status 5:4 mirror response field
// - Reserved bits read zero
// - Count reads 2^16 after reset
// - No interrupt during halt mode
// - Watchdog reset is warm, not power-on
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module wdt_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        por_i,
    input  wire logic        halt_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             fiq_o,
    output logic             wdt_reset_o
);
    import wdt_pkg::*;

    // ****************************************
    // State
    // ****************************************
    logic        en_ff,      nxt_en;
    logic [1:0]  resp_ff,    nxt_resp;
    logic        lock_ff,    nxt_lock;
    logic [3:0]  tos_ff,     nxt_tos;
    logic [31:0] count_ff,   nxt_count;
    logic        fiq_ff,     nxt_fiq;
    logic        seen_ff,    nxt_seen;
    logic        norst_ff,   nxt_norst;
    logic        wrst_ff,    nxt_wrst;
    logic [2:0]  pulse_ff,   nxt_pulse;
    logic        rout_ff,    nxt_rout;
    logic [31:0] rdat_ff,    nxt_rdat;
    logic        ack_ff,     nxt_ack;
    logic        halt_s1_ff, halt_s2_ff;
    logic        por_s1_ff,  por_s2_ff;

    logic        req;
    logic        wr;
    logic        wr_ctl;
    logic        key_ok;
    logic        expired;
    logic [31:0] load_val;

    // Request decode, answered one cycle after strobe
    assign req      = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wr       = req && wb_we_i && wb_sel_i[0];
    assign wr_ctl   = wr && (wb_adr_i[4:0] == ADDR_CONTROL);
    assign key_ok   = wr && (wb_adr_i[4:0] == ADDR_SERVICE) && wb_sel_i[1]
                      && (wb_dat_i[15:0] == SERVICE_KEY);
    assign expired  = en_ff && (count_ff == 32'h0000_0000);
    assign load_val = 32'h0000_0001 << (tos_ff + 5'(TOS_BASE));

    // Pin synchronisers
    always_ff @(posedge clk_i) begin
        halt_s1_ff <= halt_i;
        halt_s2_ff <= halt_s1_ff;
        por_s1_ff  <= por_i;
        por_s2_ff  <= por_s1_ff;
    end

    // Next-state logic
    always_comb begin
        nxt_en    = en_ff;
        nxt_resp  = resp_ff;
        nxt_lock  = lock_ff;
        nxt_tos   = tos_ff;
        nxt_count = count_ff;
        nxt_fiq   = fiq_ff;
        nxt_seen  = seen_ff;
        nxt_norst = norst_ff;
        nxt_wrst  = 1'b0;
        nxt_pulse = pulse_ff;
        if (wr_ctl) begin
            nxt_tos  = wb_dat_i[CTL_TOS_LSB +: 4];
            nxt_resp = wb_dat_i[CTL_RESP_LSB +: 2];
            if (!(lock_ff && en_ff) || wb_dat_i[CTL_EN_BIT]) begin
                nxt_en = wb_dat_i[CTL_EN_BIT];
            end
            if (wb_dat_i[CTL_LOCK_BIT] && (en_ff || wb_dat_i[CTL_EN_BIT])) begin
                nxt_lock = 1'b1;
            end
            if (!en_ff && wb_dat_i[CTL_EN_BIT]) begin
                nxt_count = load_val;
            end
        end
        if (key_ok) begin
            nxt_count = load_val;
            nxt_fiq   = 1'b0;
        end else if (expired) begin
            nxt_count = load_val;
            if (resp_ff == RESP_FIQ && !fiq_ff) begin
                if (!halt_s2_ff) begin
                    nxt_fiq  = 1'b1;
                    nxt_seen = 1'b1;
                end
            end else if (resp_ff == RESP_FIQ || resp_ff == RESP_RESET) begin
                nxt_wrst  = 1'b1;
            end
        end else if (en_ff) begin
            nxt_count = count_ff - 32'h0000_0001;
        end
        if (pulse_ff != 3'h0) begin
            nxt_pulse = pulse_ff - 3'h1;
        end
        if (nxt_wrst) begin
            nxt_pulse = RST_PULSE_LAST;
            nxt_norst = 1'b0;
        end
        // Reset output stands while the pulse counter runs
        nxt_rout = (nxt_pulse != 3'h0);
    end

    // Watchdog state registers; por marks the power-on status only
    always_ff @(posedge clk_i) begin
        if (rst_i || pulse_ff == 3'h1) begin
            en_ff    <= 1'b0;
            resp_ff  <= CTL_RESET[2:1];
            lock_ff  <= 1'b0;
            tos_ff   <= CTL_RESET[7:4];
            count_ff <= COUNT_RESET;
            fiq_ff   <= 1'b0;
            seen_ff  <= 1'b0;
            wrst_ff  <= 1'b0;
            pulse_ff <= 3'h0;
            rout_ff  <= 1'b0;
            norst_ff <= (rst_i && por_s2_ff) ? 1'b1 : norst_ff;
        end else begin
            en_ff    <= nxt_en;
            resp_ff  <= nxt_resp;
            lock_ff  <= nxt_lock;
            tos_ff   <= nxt_tos;
            count_ff <= nxt_count;
            fiq_ff   <= nxt_fiq;
            seen_ff  <= nxt_seen;
            wrst_ff  <= nxt_wrst;
            pulse_ff <= nxt_pulse;
            rout_ff  <= nxt_rout;
            norst_ff <= nxt_norst;
        end
    end

    // Read mux, reserved bits zero
    always_comb begin
        nxt_ack  = req;
        nxt_rdat = 32'h0000_0000;
        if (req && !wb_we_i) begin
            case (wb_adr_i[4:0])
                ADDR_CONTROL:  nxt_rdat[7:0] = {tos_ff, lock_ff, resp_ff, en_ff};
                ADDR_STATE:    nxt_rdat[7:0] = {seen_ff, norst_ff, resp_ff, 4'h0};
                ADDR_CNT_LOW:  nxt_rdat[7:0] = count_ff[7:0];
                ADDR_CNT_ONE:  nxt_rdat[7:0] = count_ff[15:8];
                ADDR_CNT_TWO:  nxt_rdat[7:0] = count_ff[23:16];
                ADDR_CNT_HIGH: nxt_rdat[7:0] = count_ff[31:24];
                ADDR_HALT:     nxt_rdat[0]   = halt_s2_ff;
                default:       nxt_rdat      = 32'h0000_0000;
            endcase
        end
    end

    // Bus answer registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff  <= 1'b0;
            rdat_ff <= 32'h0000_0000;
        end else begin
            ack_ff  <= nxt_ack;
            rdat_ff <= nxt_rdat;
        end
    end

    assign wb_ack_o    = ack_ff;
    assign wb_dat_o    = rdat_ff;
    assign fiq_o       = fiq_ff;
    assign wdt_reset_o = rout_ff;

    // ****************************************
    // Checks
    // ****************************************
    chk_count_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (!en_ff && !wr_ctl && !key_ok && pulse_ff == 3'h0) |=> $stable(count_ff))
        else $error("count moved while disabled");
    chk_count_dec: assert property (@(posedge clk_i) disable iff (rst_i)
        (en_ff && !expired && !key_ok && pulse_ff == 3'h0) |=> count_ff == $past(count_ff) - 1)
        else $error("count did not decrement");
    chk_key_load: assert property (@(posedge clk_i) disable iff (rst_i)
        (key_ok && pulse_ff == 3'h0) |=> count_ff == (32'h1 << ($past(tos_ff) + 16)) && !fiq_ff)
        else $error("key did not reload");
    chk_fiq_first: assert property (@(posedge clk_i) disable iff (rst_i)
        (expired && resp_ff == RESP_FIQ && !fiq_ff && !halt_s2_ff && !key_ok && pulse_ff == 3'h0)
        |=> fiq_ff && seen_ff && !wrst_ff)
        else $error("first timeout missed interrupt");
    chk_second_rst: assert property (@(posedge clk_i) disable iff (rst_i)
        (expired && resp_ff == RESP_FIQ && fiq_ff && !key_ok && pulse_ff == 3'h0) |=> wdt_reset_o)
        else $error("second timeout did not reset");
    chk_direct_rst: assert property (@(posedge clk_i) disable iff (rst_i)
        (expired && resp_ff == RESP_RESET && !key_ok && pulse_ff == 3'h0) |=> wrst_ff ##1 !norst_ff)
        else $error("timeout did not reset");
    chk_halt_fiq: assert property (@(posedge clk_i) disable iff (rst_i)
        (halt_s2_ff && !fiq_ff) |=> !fiq_ff)
        else $error("interrupt raised in halt");
    chk_lock_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (lock_ff && en_ff && pulse_ff == 3'h0) |=> lock_ff && en_ff)
        else $error("locked enable cleared");
    chk_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
endmodule : wdt_top
`default_nettype wire

// [inc/wdt_pkg.sv]
package wdt_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [4:0]  ADDR_CONTROL    = 5'h00;
    localparam logic [4:0]  ADDR_SERVICE    = 5'h04;
    localparam logic [4:0]  ADDR_STATE      = 5'h08;
    localparam logic [4:0]  ADDR_CNT_LOW    = 5'h0c;
    localparam logic [4:0]  ADDR_CNT_ONE    = 5'h10;
    localparam logic [4:0]  ADDR_CNT_TWO    = 5'h14;
    localparam logic [4:0]  ADDR_CNT_HIGH   = 5'h18;
    localparam logic [4:0]  ADDR_HALT       = 5'h1c;

    // ****************************************
    // Field positions and values
    // ****************************************
    localparam int          CTL_EN_BIT      = 0;
    localparam int          CTL_RESP_LSB    = 1;
    localparam int          CTL_LOCK_BIT    = 3;
    localparam int          CTL_TOS_LSB     = 4;
    localparam int          ST_RESP_LSB     = 4;
    localparam int          ST_NORST_BIT    = 6;
    localparam int          ST_FIQ_BIT      = 7;
    localparam int          TOS_BASE        = 16;
    localparam logic [15:0] SERVICE_KEY     = 16'h1984;
    localparam logic [1:0]  RESP_RESET      = 2'b00;
    localparam logic [1:0]  RESP_FIQ        = 2'b11;
    localparam logic [31:0] COUNT_RESET     = 32'h0001_0000;
    localparam logic [7:0]  CTL_RESET       = 8'h00;
    localparam int          RST_PULSE_CYC   = 4;
    localparam logic [2:0]  RST_PULSE_LAST  = 3'(RST_PULSE_CYC - 1);
endpackage : wdt_pkg

// [testbench/tb_watchdog_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_watchdog_timer;
    import wdt_pkg::*;
    typedef struct packed {logic we; logic [4:0] adr; logic [31:0] dat; logic [31:0] exp;} wdt_row_t;
    logic        clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b1, halt_i = 1'b0;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [31:0] adr = 32'h0, dat = 32'h0, dat_o, q;
    logic        ack, fast_interrupt, wrst;
    int          fail_count = 0, n_tests = 0, cyc_cnt = 0;
    // ****************************************
    // Ordinary cases: write, or read and expect
    // ****************************************
    wdt_row_t rows [10] = '{
        '{1'b0, ADDR_CONTROL, 32'h0, 32'h0},
        '{1'b0, ADDR_STATE, 32'h0, 32'h0000_0040},
        '{1'b0, ADDR_CNT_TWO, 32'h0, 32'h0000_0001},
        '{1'b0, ADDR_CNT_HIGH, 32'h0, 32'h0},
        '{1'b1, ADDR_CONTROL, 32'hffff_ff06, 32'h0},
        '{1'b0, ADDR_CONTROL, 32'h0, 32'h0000_0006},
        '{1'b0, ADDR_STATE, 32'h0, 32'h0000_0070},
        '{1'b1, ADDR_CNT_LOW, 32'h0000_00ff, 32'h0},
        '{1'b0, ADDR_CNT_LOW, 32'h0, 32'h0},
        '{1'b0, 5'h1e, 32'h0, 32'h0}};
    wdt_top u_wdt_top (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .halt_i(halt_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat),
        .wb_sel_i(4'hf), .wb_dat_o(dat_o), .wb_ack_o(ack), .fiq_o(fast_interrupt), .wdt_reset_o(wrst));
    // Clock and hang guard
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 90000) begin
            fail_count++;
            end_sim();
        end
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // One classic cycle; data taken at the ack edge
    task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= {27'h0, a};
        dat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : xfer
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check("register", q, exp);
    endtask : rd_chk
    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        por_i <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            xfer(rows[i].we, rows[i].adr, rows[i].dat);
            if (!rows[i].we) check("row", q, rows[i].exp);
        end
        xfer(1'b1, ADDR_CONTROL, 32'h0000_0007);
        rd_chk(ADDR_CNT_TWO, 32'h0);
        rd_chk(ADDR_CNT_ONE, 32'h0000_00ff);
        xfer(1'b1, ADDR_CONTROL, 32'h0000_00f7);
        rd_chk(ADDR_CNT_ONE, 32'h0000_00ff);
        xfer(1'b1, ADDR_SERVICE, 32'h0000_1985);
        rd_chk(ADDR_CNT_TWO, 32'h0);
        xfer(1'b1, ADDR_CONTROL, 32'h0000_00f6);
        xfer(1'b1, ADDR_SERVICE, {16'h0, SERVICE_KEY});
        rd_chk(ADDR_CNT_HIGH, 32'h0000_0080);
        rd_chk(ADDR_CNT_LOW, 32'h0);
        xfer(1'b1, ADDR_CONTROL, 32'h0000_0006);
        xfer(1'b1, ADDR_SERVICE, {16'h0, SERVICE_KEY});
        xfer(1'b1, ADDR_CONTROL, 32'h0000_0007);
        while (fast_interrupt !== 1'b1) @(posedge clk_i);
        check("reset_out", {31'h0, wrst}, 32'h0);
        rd_chk(ADDR_STATE, 32'h0000_00f0);
        xfer(1'b1, ADDR_SERVICE, {16'h0, SERVICE_KEY});
        check("fiq", {31'h0, fast_interrupt}, 32'h0);
        // Mid-run reset with power-on low keeps status bit 6
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd_chk(ADDR_STATE, 32'h0000_0040);
        rd_chk(ADDR_CONTROL, 32'h0);
        xfer(1'b1, ADDR_CONTROL, 32'h0000_0009);
        xfer(1'b1, ADDR_CONTROL, 32'h0);
        rd_chk(ADDR_CONTROL, 32'h0000_0009);
        end_sim();
    end
endmodule : tb_watchdog_timer
`default_nettype wire
